// ==== design/ctl_defs.svh ====
// ctl_defs.svh: numeric constants of the control port front end
// assumes: included by bare name wherever the numbers are used
`ifndef CTL_DEFS_SVH
`define CTL_DEFS_SVH

// ----------------------------------------------------------------
// clock and reset timing
// ----------------------------------------------------------------
`define CTL_MCLK_NS 50
`define CTL_RST_LOW_NS 10
`define CTL_RST_LOW_CYC ((`CTL_RST_LOW_NS + `CTL_MCLK_NS - 1) / `CTL_MCLK_NS)
`define CTL_PIN_LAG_CYC 4

// ----------------------------------------------------------------
// synchroniser vector bit positions
// ----------------------------------------------------------------
`define CTL_SYNC_W 7
`define CTL_S_RSTN 0
`define CTL_S_SEL 1
`define CTL_S_MFPA 2
`define CTL_S_MFPB 3
`define CTL_S_MOSI 4
`define CTL_S_SCL 5
`define CTL_S_SDA 6

// ----------------------------------------------------------------
// command, address and page
// ----------------------------------------------------------------
`define CTL_CMD_RW_BIT 0
`define CTL_RW_WRITE 1'h0
`define CTL_RW_READ 1'h1
`define CTL_I2C_ADDR_HI 5'h06
`define CTL_PAGE_REG 7'h00
`define CTL_PAGE_RESET 1'h0

`endif

// ==== design/ctl_pkg.sv ====
// ctl_pkg: state types of both ends of the control port
// assumes: nothing beyond the compiler
package ctl_pkg;

  // two-wire slave states
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_REG = 3'h2,
    I2C_WDATA = 3'h3,
    I2C_ACK = 3'h4,
    I2C_RDATA = 3'h5,
    I2C_MACK = 3'h6
  } i2c_state_t;

  // host sequencer states
  typedef enum logic [1:0] {
    H_RST = 2'h0,
    H_IDLE = 2'h1,
    H_XFER = 2'h2,
    H_GAP = 2'h3
  } host_state_t;

endpackage : ctl_pkg

// ==== design/ctl_link_if.sv ====
// ctl_link_if: pins between the host and the codec control port
// assumes: the bench drives scl_m_oe and sda_m_oe as two-wire master
`timescale 1ns/1ns
interface ctl_link_if;
  logic select;
  logic reset_n;
  logic multifunction_pin_a;
  logic multifunction_pin_b;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // pulled-up lines resolved from the enables
  assign miso = miso_oe ? miso_o : 1'b1;
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | (sda_dev_oe & ~sda_dev_o));

  modport host (
    output select,
    output reset_n,
    output multifunction_pin_a,
    output multifunction_pin_b,
    output mosi,
    input miso
  );

  modport device (
    input select,
    input reset_n,
    input multifunction_pin_a,
    input multifunction_pin_b,
    input mosi,
    input scl,
    input sda,
    output miso_o,
    output miso_oe,
    output sda_dev_o,
    output sda_dev_oe
  );
endinterface : ctl_link_if

// ==== design/ctl_device.sv ====
// ctl_device: codec control port, spi or two-wire slave, two register pages
// assumes: all link pins are asynchronous to mclk; bench resolves wires
`timescale 1ns/1ns
`include "ctl_defs.svh"
module ctl_device (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link pins
  ctl_link_if.device link,
  // status
  output logic spi_mode,
  output logic ready,
  output logic active_page,
  // register write report
  output logic reg_wr_stb,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`CTL_SYNC_W-1:0] pin_raw;
  logic [`CTL_SYNC_W-1:0] s1_q;
  logic [`CTL_SYNC_W-1:0] s2_q;
  logic [`CTL_SYNC_W-1:0] s3_q;
  logic [`CTL_SYNC_W-1:0] f_q;
  logic [`CTL_SYNC_W-1:0] f_d;
  logic [`CTL_SYNC_W-1:0] rise;
  logic [`CTL_SYNC_W-1:0] fall;

  assign pin_raw = {link.sda, link.scl, link.mosi, link.multifunction_pin_b,
                    link.multifunction_pin_a, link.select, link.reset_n};

  always_comb begin
    f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
    rise = f_d & ~f_q;
    fall = ~f_d & f_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= 7'h7f;
      s2_q <= 7'h7f;
      s3_q <= 7'h7f;
      f_q <= 7'h7f;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // ----------------------------------------------------------------
  // register pages
  // ----------------------------------------------------------------
  logic [7:0] mem [0:255];

  function automatic logic [7:0] read_fn(input logic pg, input logic [6:0] a);
    if (a == `CTL_PAGE_REG) begin
      return {7'h00, pg};
    end
    return mem[{pg, a}];
  endfunction : read_fn

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  logic hw_rst;
  logic start;
  logic stop;
  logic [6:0] dev_addr;
  logic mode_q, mode_d;
  logic seen_q, seen_d;
  logic page_q, page_d;
  ctl_pkg::i2c_state_t st_q, st_d, nxt_q, nxt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic [6:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic hdr_q, hdr_d;
  logic out_q, out_d;
  logic oe_q, oe_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;

  assign hw_rst = ~f_d[`CTL_S_RSTN];
  assign start = f_d[`CTL_S_SCL] & f_q[`CTL_S_SCL] & fall[`CTL_S_SDA];
  assign stop = f_d[`CTL_S_SCL] & f_q[`CTL_S_SCL] & rise[`CTL_S_SDA];
  assign dev_addr = {`CTL_I2C_ADDR_HI, f_d[`CTL_S_MFPB], f_d[`CTL_S_MFPA]};

  always_comb begin
    mode_d = mode_q;
    seen_d = seen_q;
    page_d = page_q;
    st_d = st_q;
    nxt_d = nxt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    hdr_d = hdr_q;
    out_d = out_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    if (hw_rst) begin
      seen_d = 1'b1;
      page_d = `CTL_PAGE_RESET;
      mode_d = f_d[`CTL_S_SEL];
      st_d = ctl_pkg::I2C_IDLE;
      cnt_d = 4'h0;
      hdr_d = 1'b0;
      out_d = 1'b0;
      oe_d = 1'b0;
    end else if (!seen_q) begin
      oe_d = 1'b0;
    end else if (mode_q) begin
      if (f_d[`CTL_S_MFPA]) begin
        cnt_d = 4'h0;
        hdr_d = 1'b0;
        oe_d = 1'b0;
        out_d = 1'b0;
      end else begin
        oe_d = 1'b1;
        if (rise[`CTL_S_MFPB]) begin
          out_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
        if (fall[`CTL_S_MFPB]) begin
          sh_d = {sh_q[6:0], f_d[`CTL_S_MOSI]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            cnt_d = 4'h0;
            if (!hdr_q) begin
              hdr_d = 1'b1;
              ptr_d = sh_d[7:1];
              rd_d = sh_d[`CTL_CMD_RW_BIT];
              tx_d = read_fn(page_q, sh_d[7:1]);
            end else begin
              if (rd_q == `CTL_RW_WRITE) begin
                wr_d = 1'b1;
                wa_d = {page_q, ptr_q};
                wd_d = sh_d;
              end
              ptr_d = ptr_q + 7'h01;
              tx_d = read_fn(page_q, ptr_q + 7'h01);
            end
          end
        end
      end
    end else if (stop) begin
      st_d = ctl_pkg::I2C_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d = ctl_pkg::I2C_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ctl_pkg::I2C_IDLE: begin
          oe_d = 1'b0;
        end
        ctl_pkg::I2C_ADDR, ctl_pkg::I2C_REG, ctl_pkg::I2C_WDATA: begin
          if (rise[`CTL_S_SCL]) begin
            sh_d = {sh_q[6:0], f_d[`CTL_S_SDA]};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall[`CTL_S_SCL] && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            oe_d = 1'b1;
            st_d = ctl_pkg::I2C_ACK;
            if (st_q == ctl_pkg::I2C_ADDR) begin
              rd_d = sh_q[0];
              tx_d = read_fn(page_q, ptr_q);
              nxt_d = sh_q[0] ? ctl_pkg::I2C_RDATA : ctl_pkg::I2C_REG;
              if (sh_q[7:1] != dev_addr) begin
                oe_d = 1'b0;
                st_d = ctl_pkg::I2C_IDLE;
              end
            end else if (st_q == ctl_pkg::I2C_REG) begin
              ptr_d = sh_q[6:0];
              nxt_d = ctl_pkg::I2C_WDATA;
            end else begin
              wr_d = 1'b1;
              wa_d = {page_q, ptr_q};
              wd_d = sh_q;
              ptr_d = ptr_q + 7'h01;
              nxt_d = ctl_pkg::I2C_WDATA;
            end
          end
        end
        ctl_pkg::I2C_ACK: begin
          if (fall[`CTL_S_SCL]) begin
            cnt_d = 4'h0;
            oe_d = 1'b0;
            st_d = nxt_q;
            if (nxt_q == ctl_pkg::I2C_RDATA) begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = 4'h1;
            end
          end
        end
        ctl_pkg::I2C_RDATA: begin
          if (fall[`CTL_S_SCL]) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = ctl_pkg::I2C_MACK;
            end else begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ctl_pkg::I2C_MACK: begin
          if (rise[`CTL_S_SCL]) begin
            st_d = ctl_pkg::I2C_IDLE;
            if (!f_d[`CTL_S_SDA]) begin
              ptr_d = ptr_q + 7'h01;
              tx_d = read_fn(page_q, ptr_q + 7'h01);
              nxt_d = ctl_pkg::I2C_RDATA;
              st_d = ctl_pkg::I2C_ACK;
            end
          end
        end
        default: begin
          st_d = ctl_pkg::I2C_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
    if (wr_d && wa_d[6:0] == `CTL_PAGE_REG) begin
      page_d = wd_d[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      seen_q <= 1'b0;
      page_q <= `CTL_PAGE_RESET;
      st_q <= ctl_pkg::I2C_IDLE;
      nxt_q <= ctl_pkg::I2C_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 7'h00;
      rd_q <= 1'b0;
      hdr_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      seen_q <= seen_d;
      page_q <= page_d;
      st_q <= st_d;
      nxt_q <= nxt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      hdr_q <= hdr_d;
      out_q <= out_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_d) begin
      mem[wa_d] <= wd_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.miso_o = out_q;
  assign link.miso_oe = oe_q & mode_q;
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = oe_q & ~mode_q;
  assign spi_mode = mode_q;
  assign ready = seen_q;
  assign active_page = page_q;
  assign reg_wr_stb = wr_q;
  assign reg_wr_addr = wa_q;
  assign reg_wr_data = wd_q;

endmodule : ctl_device

// ==== design/ctl_host.sv ====
// ctl_host: host end, drives straps, reset pulse and spi register transfers
// assumes: two-wire master, if used, is outside this module
`timescale 1ns/1ns
`include "ctl_defs.svh"
module ctl_host #(
  parameter int SCLK_HALF = 8,
  parameter int RESET_LOW_CYCLES = `CTL_RST_LOW_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // straps
  input wire logic strap_spi,
  input wire logic [1:0] addr_lsb,
  // request
  input wire logic req,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  // answer
  output logic done,
  output logic [7:0] rdata,
  // link pins
  ctl_link_if.host link
);

  localparam int HOLD = RESET_LOW_CYCLES + `CTL_PIN_LAG_CYC;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ctl_pkg::host_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] div_q, div_d;
  logic sel_q, sel_d;
  logic [1:0] lsb_q, lsb_d;
  logic rstn_q, rstn_d;
  logic cs_q, cs_d;
  logic sclk_q, sclk_d;
  logic mosi_q, mosi_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic done_q, done_d;
  logic [2:0] ms_q, ms_d;
  logic mf_q, mf_d;
  logic tick;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    div_d = div_q;
    sel_d = sel_q;
    lsb_d = lsb_q;
    rstn_d = rstn_q;
    cs_d = cs_q;
    sclk_d = sclk_q;
    mosi_d = mosi_q;
    sh_d = sh_q;
    rx_d = rx_q;
    done_d = 1'b0;
    ms_d = {ms_q[1:0], link.miso};
    mf_d = (ms_q[1] == ms_q[2]) ? ms_q[2] : mf_q;
    tick = (div_q == 8'(SCLK_HALF - 1));
    unique case (st_q)
      ctl_pkg::H_RST: begin
        sel_d = strap_spi;
        lsb_d = addr_lsb;
        rstn_d = 1'b0;
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(HOLD - 1)) begin
          rstn_d = 1'b1;
          cnt_d = 6'h00;
          st_d = ctl_pkg::H_IDLE;
        end
      end
      ctl_pkg::H_IDLE: begin
        if (req && sel_q) begin
          sh_d = {req_addr, req_write ? `CTL_RW_WRITE : `CTL_RW_READ, req_wdata};
          cs_d = 1'b0;
          div_d = 8'h00;
          cnt_d = 6'h00;
          st_d = ctl_pkg::H_XFER;
        end
      end
      ctl_pkg::H_XFER: begin
        div_d = div_q + 8'h01;
        if (tick) begin
          div_d = 8'h00;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h20) begin
            rx_d = {rx_q[6:0], mf_d};
            done_d = 1'b1;
            cs_d = 1'b1;
            cnt_d = 6'h00;
            st_d = ctl_pkg::H_GAP;
          end else begin
            sclk_d = ~sclk_q;
            if (!sclk_q) begin
              if (cnt_q != 6'h00) begin
                rx_d = {rx_q[6:0], mf_d};
              end
              mosi_d = sh_q[15];
              sh_d = {sh_q[14:0], 1'b0};
            end
          end
        end
      end
      ctl_pkg::H_GAP: begin
        div_d = div_q + 8'h01;
        if (tick) begin
          div_d = 8'h00;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h01) begin
            cnt_d = 6'h00;
            st_d = ctl_pkg::H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ctl_pkg::H_RST;
      cnt_q <= 6'h00;
      div_q <= 8'h00;
      sel_q <= 1'b0;
      lsb_q <= 2'h0;
      rstn_q <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q <= 16'h0000;
      rx_q <= 8'h00;
      done_q <= 1'b0;
      ms_q <= 3'h7;
      mf_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      sel_q <= sel_d;
      lsb_q <= lsb_d;
      rstn_q <= rstn_d;
      cs_q <= cs_d;
      sclk_q <= sclk_d;
      mosi_q <= mosi_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      done_q <= done_d;
      ms_q <= ms_d;
      mf_q <= mf_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.select = sel_q;
  assign link.reset_n = rstn_q;
  assign link.multifunction_pin_a = sel_q ? cs_q : lsb_q[0];
  assign link.multifunction_pin_b = sel_q ? sclk_q : lsb_q[1];
  assign link.mosi = mosi_q;
  assign busy = (st_q != ctl_pkg::H_IDLE) | ~sel_q;
  assign done = done_q;
  assign rdata = rx_q;

endmodule : ctl_host

// ==== test/ctl_port_asserts.sv ====
// ctl_port_asserts: pin-level checks on the control link
// assumes: placed in tb_top beside the link interface, one mclk domain
`timescale 1ns/1ns
module ctl_port_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link pins
  input wire logic select,
  input wire logic reset_n,
  input wire logic multifunction_pin_a,
  input wire logic multifunction_pin_b,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic mode_q;
  logic mode_d;
  logic seen_q;
  logic seen_d;

  // ----------------------------------------------------------------
  // latched mode and reset history
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = reset_n ? mode_q : select;
    seen_d = seen_q | ~reset_n;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  spi_only_a: assert property (miso_oe |-> mode_q)
    else $error("miso driven outside spi mode");
  twowire_only_a: assert property (sda_dev_oe |-> !mode_q)
    else $error("sda pulled outside two-wire mode");
  unready_quiet_a: assert property (!seen_q |-> !miso_oe && !sda_dev_oe)
    else $error("pin driven before hardware reset");
  cs_release_a: assert property ((select && multifunction_pin_a) [*8] |-> !miso_oe)
    else $error("miso driven while deselected");
  open_drain_a: assert property (sda_dev_oe |-> !sda_dev_o && !select)
    else $error("sda driven high");
  miso_hold_a: assert property (
    (miso_oe && !multifunction_pin_b && !multifunction_pin_a) [*6] |=> (!miso_oe || $stable(miso_o)))
    else $error("miso moved while clock low");
  sda_hold_a: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*4])
    else $error("sda pull too short");
  reset_quiet_a: assert property (!reset_n [*4] |-> !miso_oe && !sda_dev_oe)
    else $error("pin driven during hardware reset");
endmodule : ctl_port_asserts

// ==== test/tb_top.sv ====
// tb_top: host and device joined by the link; spi and two-wire traffic
// assumes: design files compiled first, ctl_defs.svh on the include path
`timescale 1ns/1ns
module tb_top;
  logic mclk, rst, strap_spi, req, req_write, busy, done, spi_mode, ready, active_page;
  logic reg_wr_stb;
  logic [1:0] addr_lsb;
  logic [6:0] req_addr;
  logic [6:0] ra [0:5];
  logic [7:0] req_wdata, rdata, reg_wr_addr, reg_wr_data;
  logic [7:0] mem [0:255];
  logic [31:0] seed, w;
  logic [15:0] wr_q [$];
  int fail_count, cmp_count, page;

  ctl_link_if ctl_link_if_inst ();
  ctl_host ctl_host_inst (.mclk(mclk), .rst(rst), .strap_spi(strap_spi), .addr_lsb(addr_lsb),
    .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .rdata(rdata), .link(ctl_link_if_inst));
  ctl_device ctl_device_inst (.mclk(mclk), .rst(rst), .link(ctl_link_if_inst),
    .spi_mode(spi_mode), .ready(ready), .active_page(active_page), .reg_wr_stb(reg_wr_stb),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  ctl_port_asserts ctl_port_asserts_inst (.mclk(mclk), .rst(rst),
    .select(ctl_link_if_inst.select), .reset_n(ctl_link_if_inst.reset_n),
    .multifunction_pin_a(ctl_link_if_inst.multifunction_pin_a),
    .multifunction_pin_b(ctl_link_if_inst.multifunction_pin_b),
    .miso_o(ctl_link_if_inst.miso_o), .miso_oe(ctl_link_if_inst.miso_oe),
    .sda_dev_o(ctl_link_if_inst.sda_dev_o), .sda_dev_oe(ctl_link_if_inst.sda_dev_oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // register write reports from the device
  always @(posedge mclk) begin
    if (reg_wr_stb === 1'b1) wr_q.push_back({reg_wr_addr, reg_wr_data});
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic sig(input int k);
    return (k == 0) ? ~busy : ((k == 1) ? done : ((k == 2) ? ready : ctl_link_if_inst.reset_n));
  endfunction : sig

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic wait_sig(input int k, input int lim);
    int n;
    n = 0;
    while (sig(k) !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim) begin
        fail_count++;
        results();
      end
    end
  endtask : wait_sig

  task automatic expect_wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic [15:0] g;
    n = 0;
    while (wr_q.size() == 0) begin
      @(posedge mclk);
      n++;
      if (n > 40) begin
        fail_count++;
        results();
      end
    end
    g = wr_q.pop_front();
    cmp_byte(g[15:8], a);
    cmp_byte(g[7:0], d);
  endtask : expect_wr

  task automatic do_reset(input logic spi, input logic [1:0] lsb);
    @(posedge mclk);
    strap_spi <= spi;
    addr_lsb <= lsb;
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    page = 0;
    @(posedge mclk);
    #1;
    cmp_bit(ready, 1'b0);
    cmp_bit(ctl_link_if_inst.reset_n, 1'b0);
    wait_sig(2, 100);
    wait_sig(3, 100);
    repeat (4) @(posedge mclk);
    #1;
    cmp_bit(spi_mode, spi);
    cmp_bit(active_page, 1'b0);
  endtask : do_reset

  task automatic spi_xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
    wait_sig(0, 3000);
    @(posedge mclk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    @(posedge mclk);
    req <= 1'b0;
    wait_sig(1, 400);
    if (wr) begin
      mem[{page[0], a}] = d;
      expect_wr({page[0], a}, d);
      if (a == 7'h00) page = d[0];
    end else begin
      cmp_byte(rdata, (a == 7'h00) ? {7'h00, page[0]} : mem[{page[0], a}]);
    end
  endtask : spi_xfer

  // ----------------------------------------------------------------
  // two-wire master, 400 ns clock period
  // ----------------------------------------------------------------
  task automatic i2c_bit(input logic b, output logic r);
    @(posedge mclk);
    ctl_link_if_inst.sda_m_oe <= ~b;
    repeat (2) @(posedge mclk);
    ctl_link_if_inst.scl_m_oe <= 1'b0;
    repeat (2) @(posedge mclk);
    r = ctl_link_if_inst.sda;
    @(posedge mclk);
    ctl_link_if_inst.scl_m_oe <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : i2c_bit

  task automatic i2c_cond(input logic stop);
    @(posedge mclk);
    ctl_link_if_inst.sda_m_oe <= stop;
    repeat (2) @(posedge mclk);
    ctl_link_if_inst.scl_m_oe <= 1'b0;
    repeat (4) @(posedge mclk);
    ctl_link_if_inst.sda_m_oe <= ~stop;
    repeat (4) @(posedge mclk);
    ctl_link_if_inst.scl_m_oe <= ~stop;
  endtask : i2c_cond

  task automatic i2c_byte(input logic [7:0] b, input logic m, output logic [7:0] r,
                          output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], s);
      r[i] = s;
    end
    i2c_bit(m, s);
    ak = ~s;
  endtask : i2c_byte

  task automatic i2c_txn(input logic [6:0] dev, input logic [6:0] r, input logic [7:0] d,
                         input logic match);
    logic [7:0] got;
    logic ak;
    i2c_cond(1'b0);
    i2c_byte({dev, 1'b0}, 1'b1, got, ak);
    cmp_bit(ak, match);
    i2c_byte({1'b0, r}, 1'b1, got, ak);
    i2c_byte(d, 1'b1, got, ak);
    i2c_cond(1'b1);
    if (match) begin
      mem[{page[0], r}] = d;
      expect_wr({page[0], r}, d);
    end
    i2c_cond(1'b0);
    i2c_byte({dev, 1'b0}, 1'b1, got, ak);
    i2c_byte({1'b0, r}, 1'b1, got, ak);
    i2c_cond(1'b0);
    i2c_byte({dev, 1'b1}, 1'b1, got, ak);
    i2c_byte(8'hFF, 1'b1, got, ak);
    i2c_cond(1'b1);
    if (match) cmp_byte(got, mem[{page[0], r}]);
    cmp_bit(wr_q.size() == 0, 1'b1);
  endtask : i2c_txn

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    strap_spi = 1'b1;
    addr_lsb = 2'h0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 7'h00;
    req_wdata = 8'h00;
    ctl_link_if_inst.scl_m_oe = 1'b0;
    ctl_link_if_inst.sda_m_oe = 1'b0;
    seed = 32'h0000_A489;
    fail_count = 0;
    cmp_count = 0;
    page = 0;
    do_reset(1'b1, 2'h0);
    for (int i = 0; i < 6; i++) begin
      w = xs();
      ra[i] = {w[6:1], 1'b1};
      spi_xfer(1'b1, ra[i], w[15:8]);
    end
    for (int i = 0; i < 6; i++) spi_xfer(1'b0, ra[i], 8'h00);
    spi_xfer(1'b1, 7'h00, 8'h01);
    cmp_bit(active_page, 1'b1);
    spi_xfer(1'b1, 7'h05, 8'hA5);
    spi_xfer(1'b0, 7'h00, 8'h00);
    spi_xfer(1'b0, 7'h05, 8'h00);
    i2c_txn(7'h18, 7'h10, 8'h3C, 1'b0);
    do_reset(1'b1, 2'h0);
    for (int k = 0; k < 4; k++) begin
      do_reset(1'b0, k[1:0]);
      cmp_bit(busy, 1'b1);
      w = xs();
      i2c_txn({5'h06, k[1:0]}, {w[6:1], 1'b1}, w[15:8], 1'b1);
      i2c_txn({5'h06, k[1:0] ^ 2'h1}, 7'h22, 8'h5A, 1'b0);
    end
    results();
  end
endmodule : tb_top
